// file: include/ipg_pkg.sv
// ============================================================
// constants, register map and state types of the pulse generator
package ipg_pkg;

    // ============================================================
    // clocks and time base
    localparam int unsigned CLK_HZ           = 125_000_000;
    localparam int unsigned TICK_HZ          = 40_000_000;
    localparam int unsigned TICK_NS          = 25;

    // ============================================================
    // setting limits and presets, in their own units
    localparam int unsigned PERIOD_MIN_NS    = 300;
    localparam int unsigned PERIOD_MAX_NS    = 400_000_000;
    localparam int unsigned PERIOD_PRESET_NS = 2_000_000;
    localparam int unsigned WIDTH_MIN_NS     = 25;
    localparam int unsigned WIDTH_MAX_NS     = 400_000_000;
    localparam int unsigned WIDTH_PRESET_NS  = 1_000_000;
    localparam int unsigned RATE_SCALE       = 10;          // rate held in 0.1 Hz steps
    localparam int unsigned RATE_MIN_DHZ     = 25;          // 2.5 Hz
    localparam int unsigned RATE_MAX_DHZ     = 33_300_000;  // 3.33 MHz
    localparam int unsigned RATE_PRESET_DHZ  = 5_000;       // 500 Hz

    // ============================================================
    // widths
    localparam int TW    = 24;
    localparam int RW    = 26;
    localparam int DW    = 32;
    localparam int AW    = 5;
    localparam int BW    = 4;
    localparam int DIV_W = 32;
    localparam int CW    = 6;
    localparam int ACC_W = 8;

    // ============================================================
    // derived tick counts
    localparam logic [TW-1:0] PERIOD_MIN_TK    = TW'(PERIOD_MIN_NS / TICK_NS);
    localparam logic [TW-1:0] PERIOD_MAX_TK    = TW'(PERIOD_MAX_NS / TICK_NS);
    localparam logic [TW-1:0] PERIOD_PRESET_TK = TW'(PERIOD_PRESET_NS / TICK_NS);
    localparam logic [TW-1:0] WIDTH_MIN_TK     = TW'(WIDTH_MIN_NS / TICK_NS);
    localparam logic [TW-1:0] WIDTH_MAX_TK     = TW'(WIDTH_MAX_NS / TICK_NS);
    localparam logic [TW-1:0] WIDTH_PRESET_TK  = TW'(WIDTH_PRESET_NS / TICK_NS);
    localparam logic [TW-1:0] WIDTH_GUARD_TK   = TW'(1);
    localparam logic [RW-1:0] RATE_MIN         = RW'(RATE_MIN_DHZ);
    localparam logic [RW-1:0] RATE_MAX         = RW'(RATE_MAX_DHZ);
    localparam logic [RW-1:0] RATE_PRESET      = RW'(RATE_PRESET_DHZ);
    // ticks per second times rate scale: period_ticks * rate_dhz = this
    localparam logic [DIV_W-1:0] RECIP_NUM     = DIV_W'(64'(TICK_HZ) * 64'(RATE_SCALE));
    // fractional tick: add TICK_ADD per clock, tick on wrap past TICK_MOD
    localparam logic [ACC_W-1:0] TICK_ADD      = ACC_W'(TICK_HZ / 1_000_000);
    localparam logic [ACC_W-1:0] TICK_MOD      = ACC_W'(CLK_HZ / 1_000_000);

    // ============================================================
    // register map (byte addresses)
    localparam logic [AW-1:0] REG_CTRL   = 5'h00;
    localparam logic [AW-1:0] REG_PERIOD = 5'h04;
    localparam logic [AW-1:0] REG_RATE   = 5'h08;
    localparam logic [AW-1:0] REG_WIDTH  = 5'h0C;
    localparam logic [AW-1:0] REG_DELAY  = 5'h10;
    localparam logic [AW-1:0] REG_STATUS = 5'h14;

    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_MODE_W     = 2;
    localparam int CTRL_PRESET_BIT = 8;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_PULSE_BIT  = 1;
    localparam int STAT_EXT_BIT    = 2;
    localparam int STAT_TRIG_BIT   = 3;
    localparam logic [DW-1:0] DATA_ZERO = 32'h0000_0000;

    // ============================================================
    // types
    typedef enum logic [1:0] {MODE_AUTO, MODE_GATE, MODE_TRIG} ipg_mode_e;
    typedef enum logic [1:0] {PH_IDLE, PH_DELAY, PH_HIGH} ipg_phase_e;
    typedef enum logic [1:0] {OP_NONE, OP_PERIOD, OP_RATE} ipg_op_e;

    typedef struct packed {
        ipg_mode_e         mode;
        logic [TW-1:0]     period;
        logic [RW-1:0]     rate;
        logic [TW-1:0]     width;
        logic [TW-1:0]     delay;
    } ipg_cfg_s;

    typedef struct packed {
        ipg_cfg_s          cfg;
        logic              waitreq;
        logic [DW-1:0]     rdata;
        ipg_op_e           op;
        logic              div_start;
        logic [DIV_W-1:0]  div_dvs;
        logic              ext;
        logic              ext_prev;
        logic              trig_pend;
        ipg_phase_e        phase;
        logic [TW-1:0]     cnt;
        logic              pulse;
    } ipg_main_s;

    typedef struct packed {
        logic              busy;
        logic              done;
        logic [CW-1:0]     cnt;
        logic [DIV_W-1:0]  rem;
        logic [DIV_W-1:0]  quo;
        logic [DIV_W-1:0]  dvs;
    } ipg_div_s;

    typedef struct packed {
        logic [ACC_W-1:0]  acc;
        logic              tick;
    } ipg_tick_s;

    localparam ipg_cfg_s CFG_PRESET = '{
        mode:   MODE_AUTO,
        period: PERIOD_PRESET_TK,
        rate:   RATE_PRESET,
        width:  WIDTH_PRESET_TK,
        delay:  '0
    };

endpackage

// file: src/ipg_tick_gen.sv
`timescale 1ns/1ps
// ============================================================
// fractional tick source, one tick per 25 ns on average
module ipg_tick_gen
    import ipg_pkg::*;
#(
    parameter logic [ACC_W-1:0] ADD = TICK_ADD,
    parameter logic [ACC_W-1:0] MOD = TICK_MOD
) (
    // clock and reset
    input  wire logic CLK,
    input  wire logic RSTN,
    // tick strobe
    output      logic TICK
);

    ipg_tick_s s_ff;
    ipg_tick_s nxt_s;
    logic [ACC_W:0] sum;

    // accumulate and wrap; ticks jitter by one clock, mean rate is exact
    always_comb begin
        nxt_s = s_ff;
        sum = {1'b0, s_ff.acc} + {1'b0, ADD};
        if (sum >= {1'b0, MOD}) begin
            nxt_s.acc  = ACC_W'(sum - {1'b0, MOD});
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.acc  = sum[ACC_W-1:0];
            nxt_s.tick = 1'b0;
        end
    end

    // state register
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign TICK = s_ff.tick;

endmodule

// file: src/ipg_div.sv
`timescale 1ns/1ps
// ============================================================
// serial restoring divider, one quotient bit per clock
module ipg_div
    import ipg_pkg::*;
(
    // clock and reset
    input  wire logic             CLK,
    input  wire logic             RSTN,
    // request
    input  wire logic             START,
    input  wire logic [DIV_W-1:0] DIVIDEND,
    input  wire logic [DIV_W-1:0] DIVISOR,
    // answer
    output      logic             DONE,
    output      logic [DIV_W-1:0] QUOTIENT
);

    ipg_div_s     s_ff;
    ipg_div_s     nxt_s;
    logic [DIV_W:0] trial;

    // start ignored while busy; caller never issues one then
    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        trial = {s_ff.rem, s_ff.quo[DIV_W-1]};
        if (!s_ff.busy) begin
            if (START) begin
                nxt_s.busy = 1'b1;
                nxt_s.rem  = '0;
                nxt_s.quo  = DIVIDEND;
                nxt_s.dvs  = DIVISOR;
                nxt_s.cnt  = '0;
            end
        end else begin
            if (trial >= {1'b0, s_ff.dvs}) begin
                nxt_s.rem = DIV_W'(trial - {1'b0, s_ff.dvs});
                nxt_s.quo = {s_ff.quo[DIV_W-2:0], 1'b1};
            end else begin
                nxt_s.rem = trial[DIV_W-1:0];
                nxt_s.quo = {s_ff.quo[DIV_W-2:0], 1'b0};
            end
            nxt_s.cnt = CW'(s_ff.cnt + 1'b1);
            if (s_ff.cnt == CW'(DIV_W - 1)) begin
                nxt_s.busy = 1'b0;
                nxt_s.done = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign DONE     = s_ff.done;
    assign QUOTIENT = s_ff.quo;

endmodule

// file: src/ipg_top.sv
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// ============================================================
// internal pulse generator with Avalon-MM register slave
//
// What this block does
// - period clamped to 300 ns..400 ms, 25 ns steps
// - preset period is 2 ms
// - rate clamped to 2.5 Hz..3.33 MHz
// - preset rate is 500 Hz
// - last written of period/rate wins, other recomputed
// - width clamped to 25 ns..400 ms, 25 ns steps
// - preset width is 1 ms
// - width written above period forces period to width+25ns
// - preset selects free-running automatic mode
// - automatic mode pulses continuously, ignores external input
// - gate mode ANDs pulse train with external gate
// - trigger mode starts one pulse per rising edge seen while idle; edges during delay or pulse are dropped
// - triggered pulse delayed by programmable delay
module ipg_top
    import ipg_pkg::*;
(
    // clock and reset
    input  wire logic          CLK,
    input  wire logic          RSTN,
    // avalon-mm slave
    input  wire logic [AW-1:0] AVS_ADDRESS,
    input  wire logic          AVS_READ,
    input  wire logic          AVS_WRITE,
    input  wire logic [DW-1:0] AVS_WRITEDATA,
    input  wire logic [BW-1:0] AVS_BYTEENABLE,
    output      logic [DW-1:0] AVS_READDATA,
    output      logic          AVS_WAITREQUEST,
    // external gate / trigger input
    input  wire logic          EXT_PULSE_IN,
    // modulator drive
    output      logic          PULSE_OUT
);

    // ============================================================
    // reset image: presets, bus idle with waitrequest high
    localparam ipg_main_s MAIN_RESET = '{
        cfg:       CFG_PRESET,
        waitreq:   1'b1,
        rdata:     '0,
        op:        OP_NONE,
        div_start: 1'b0,
        div_dvs:   '0,
        ext:       1'b0,
        ext_prev:  1'b0,
        trig_pend: 1'b0,
        phase:     PH_IDLE,
        cnt:       '0,
        pulse:     1'b0
    };

    // ============================================================
    // helpers
    function automatic logic [DW-1:0] merge_be(input logic [DW-1:0] old_v,
                                               input logic [DW-1:0] new_v,
                                               input logic [BW-1:0] be);
        logic [DW-1:0] res;
        res = old_v;
        for (int i = 0; i < BW; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [TW-1:0] clamp_tk(input logic [DW-1:0] v,
                                               input logic [TW-1:0] lo,
                                               input logic [TW-1:0] hi);
        logic [TW-1:0] res;
        res = v[TW-1:0];
        if (v < DW'(lo)) begin
            res = lo;
        end else if (v > DW'(hi)) begin
            res = hi;
        end
        return res;
    endfunction

    function automatic logic [RW-1:0] clamp_rate(input logic [DW-1:0] v);
        logic [RW-1:0] res;
        res = v[RW-1:0];
        if (v < DW'(RATE_MIN)) begin
            res = RATE_MIN;
        end else if (v > DW'(RATE_MAX)) begin
            res = RATE_MAX;
        end
        return res;
    endfunction

    // ============================================================
    // submodules
    ipg_main_s        s_ff;
    ipg_main_s        nxt_s;
    logic             tick;
    logic             div_done;
    logic [DIV_W-1:0] div_quo;

    // 40 MHz tick from the 125 MHz clock
    ipg_tick_gen u_tick (
        .CLK  (CLK),
        .RSTN (RSTN),
        .TICK (tick)
    );

    // reciprocal between period ticks and rate in 0.1 Hz
    ipg_div u_div (
        .CLK      (CLK),
        .RSTN     (RSTN),
        .START    (s_ff.div_start),
        .DIVIDEND (RECIP_NUM),
        .DIVISOR  (s_ff.div_dvs),
        .DONE     (div_done),
        .QUOTIENT (div_quo)
    );

    // ============================================================
    // next-state logic
    logic          accept;
    logic          rise;
    logic          train;
    logic [DW-1:0] wval;
    logic [TW-1:0] tk;
    logic [RW-1:0] rv;
    logic [TW-1:0] cnt_inc;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.waitreq   = 1'b1;
        nxt_s.div_start = 1'b0;
        wval = DATA_ZERO;
        tk = '0;
        rv = '0;
        cnt_inc = TW'(s_ff.cnt + 1'b1);

        // input taken as synchronous; one stage for edge history
        nxt_s.ext      = EXT_PULSE_IN;
        nxt_s.ext_prev = s_ff.ext;
        rise = s_ff.ext & ~s_ff.ext_prev;

        // reciprocal result lands in whichever setting was not written
        if (div_done) begin
            if (s_ff.op == OP_PERIOD) begin
                nxt_s.cfg.period = clamp_tk(div_quo, PERIOD_MIN_TK, PERIOD_MAX_TK);
            end else if (s_ff.op == OP_RATE) begin
                nxt_s.cfg.rate = clamp_rate(div_quo);
            end
            nxt_s.op = OP_NONE;
        end

        // bus: hold off while a recompute is in flight so reads stay coherent
        accept = (AVS_READ | AVS_WRITE) & s_ff.waitreq & ~s_ff.div_start
                 & (s_ff.op == OP_NONE);
        if (accept) begin
            nxt_s.waitreq = 1'b0;
            if (AVS_READ) begin
                nxt_s.rdata = DATA_ZERO; // writes leave the last read data standing
                unique case (AVS_ADDRESS)
                    REG_CTRL:   nxt_s.rdata = DW'(s_ff.cfg.mode);
                    REG_PERIOD: nxt_s.rdata = DW'(s_ff.cfg.period);
                    REG_RATE:   nxt_s.rdata = DW'(s_ff.cfg.rate);
                    REG_WIDTH:  nxt_s.rdata = DW'(s_ff.cfg.width);
                    REG_DELAY:  nxt_s.rdata = DW'(s_ff.cfg.delay);
                    REG_STATUS: begin
                        nxt_s.rdata[STAT_BUSY_BIT]  = (s_ff.op != OP_NONE);
                        nxt_s.rdata[STAT_PULSE_BIT] = s_ff.pulse;
                        nxt_s.rdata[STAT_EXT_BIT]   = s_ff.ext;
                        nxt_s.rdata[STAT_TRIG_BIT]  = (s_ff.phase != PH_IDLE);
                    end
                    default:    nxt_s.rdata = DATA_ZERO;
                endcase
            end else begin
                unique case (AVS_ADDRESS)
                    REG_CTRL: begin
                        wval = merge_be(DW'(s_ff.cfg.mode), AVS_WRITEDATA, AVS_BYTEENABLE);
                        if (wval[CTRL_PRESET_BIT]) begin
                            nxt_s.cfg   = CFG_PRESET;
                            nxt_s.phase = PH_IDLE;
                            nxt_s.cnt   = '0;
                            nxt_s.trig_pend = 1'b0;
                        end else if (wval[CTRL_MODE_LSB +: CTRL_MODE_W] != 2'h3) begin
                            // illegal mode code is ignored
                            nxt_s.cfg.mode  = ipg_mode_e'(wval[CTRL_MODE_LSB +: CTRL_MODE_W]);
                            nxt_s.phase     = PH_IDLE;
                            nxt_s.cnt       = '0;
                            nxt_s.trig_pend = 1'b0;
                        end
                    end
                    REG_PERIOD: begin
                        wval = merge_be(DW'(s_ff.cfg.period), AVS_WRITEDATA, AVS_BYTEENABLE);
                        tk = clamp_tk(wval, PERIOD_MIN_TK, PERIOD_MAX_TK);
                        nxt_s.cfg.period = tk;
                        nxt_s.div_dvs    = DIV_W'(tk);
                        nxt_s.div_start  = 1'b1;
                        nxt_s.op         = OP_RATE;
                    end
                    REG_RATE: begin
                        wval = merge_be(DW'(s_ff.cfg.rate), AVS_WRITEDATA, AVS_BYTEENABLE);
                        rv = clamp_rate(wval);
                        nxt_s.cfg.rate  = rv;
                        nxt_s.div_dvs   = DIV_W'(rv);
                        nxt_s.div_start = 1'b1;
                        nxt_s.op        = OP_PERIOD;
                    end
                    REG_WIDTH: begin
                        wval = merge_be(DW'(s_ff.cfg.width), AVS_WRITEDATA, AVS_BYTEENABLE);
                        tk = clamp_tk(wval, WIDTH_MIN_TK, WIDTH_MAX_TK);
                        nxt_s.cfg.width = tk;
                        if (tk > s_ff.cfg.period) begin
                            // may exceed the period ceiling by one tick at max width
                            nxt_s.cfg.period = TW'(tk + WIDTH_GUARD_TK);
                            nxt_s.div_dvs    = DIV_W'(tk + WIDTH_GUARD_TK);
                            nxt_s.div_start  = 1'b1;
                            nxt_s.op         = OP_RATE;
                        end
                    end
                    REG_DELAY: begin
                        wval = merge_be(DW'(s_ff.cfg.delay), AVS_WRITEDATA, AVS_BYTEENABLE);
                        nxt_s.cfg.delay = wval[TW-1:0];
                    end
                    default: begin
                        // unmapped or read-only: answered, no effect
                    end
                endcase
            end
        end

        // pulse engine, advancing only on ticks
        unique case (s_ff.cfg.mode)
            MODE_AUTO, MODE_GATE: begin
                if (tick) begin
                    if (s_ff.cnt >= TW'(s_ff.cfg.period - 1'b1)) begin
                        nxt_s.cnt = '0;
                    end else begin
                        nxt_s.cnt = cnt_inc;
                    end
                end
            end
            MODE_TRIG: begin
                // set wins over consumption: an edge in the cycle the pending trigger is taken is kept
                if (rise && s_ff.phase == PH_IDLE) begin
                    nxt_s.trig_pend = 1'b1;
                end
                if (tick) begin
                    unique case (s_ff.phase)
                        PH_IDLE: begin
                            if (s_ff.trig_pend) begin
                                nxt_s.trig_pend = rise;
                                nxt_s.cnt = '0;
                                if (s_ff.cfg.delay == '0) begin
                                    nxt_s.phase = PH_HIGH;
                                end else begin
                                    nxt_s.phase = PH_DELAY;
                                end
                            end
                        end
                        PH_DELAY: begin
                            if (cnt_inc >= s_ff.cfg.delay) begin
                                nxt_s.phase = PH_HIGH;
                                nxt_s.cnt   = '0;
                            end else begin
                                nxt_s.cnt = cnt_inc;
                            end
                        end
                        PH_HIGH: begin
                            if (cnt_inc >= s_ff.cfg.width) begin
                                nxt_s.phase = PH_IDLE;
                                nxt_s.cnt   = '0;
                            end else begin
                                nxt_s.cnt = cnt_inc;
                            end
                        end
                        default: begin
                            nxt_s.phase = PH_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                nxt_s.cfg.mode = MODE_AUTO;
            end
        endcase

        // output level, registered for a clean modulator drive
        train = (s_ff.cnt < s_ff.cfg.width);
        unique case (s_ff.cfg.mode)
            MODE_AUTO: nxt_s.pulse = train;
            MODE_GATE: nxt_s.pulse = train & s_ff.ext;
            MODE_TRIG: nxt_s.pulse = (s_ff.phase == PH_HIGH);
            default:   nxt_s.pulse = 1'b0;
        endcase
    end

    // ============================================================
    // state register
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            s_ff <= MAIN_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ============================================================
    // outputs straight from flip-flops
    assign AVS_READDATA    = s_ff.rdata;
    assign AVS_WAITREQUEST = s_ff.waitreq;
    assign PULSE_OUT       = s_ff.pulse;

endmodule

// file: sim/ipg_assertions.sv
`timescale 1ns/1ps
// ============================================================
// bus handshake and range checks at the generator ports
module ipg_assertions
    import ipg_pkg::*;
(
    // clock and reset
    input  wire logic          CLK,
    input  wire logic          RSTN,
    // avalon-mm slave
    input  wire logic [AW-1:0] AVS_ADDRESS,
    input  wire logic          AVS_READ,
    input  wire logic          AVS_WRITE,
    input  wire logic [DW-1:0] AVS_READDATA,
    input  wire logic          AVS_WAITREQUEST
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // answered read, data valid this cycle
    wire rd_ok = AVS_READ && !AVS_WAITREQUEST;
    // handshake shape, recompute stall included in the bound
    chk_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    chk_wait_cause: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
        else $error("answer without request");
    chk_wait_bound: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |-> ##[1:40] !AVS_WAITREQUEST)
        else $error("request not answered in time");
    chk_rdata_hold: assert property (!rd_ok |-> $stable(AVS_READDATA))
        else $error("read data moved outside a read answer");
    chk_unmapped_zero: assert property (rd_ok && AVS_ADDRESS > REG_STATUS |-> AVS_READDATA == DATA_ZERO)
        else $error("unmapped read not zero");
    // settings never leave their limits; width max forces one tick above
    chk_period_range: assert property (rd_ok && AVS_ADDRESS == REG_PERIOD |->
        AVS_READDATA >= 32'(PERIOD_MIN_TK) && AVS_READDATA <= 32'(PERIOD_MAX_TK) + 32'h0000_0001)
        else $error("period out of range");
    chk_rate_range: assert property (rd_ok && AVS_ADDRESS == REG_RATE |->
        AVS_READDATA >= 32'(RATE_MIN) && AVS_READDATA <= 32'(RATE_MAX))
        else $error("rate out of range");
    chk_width_range: assert property (rd_ok && AVS_ADDRESS == REG_WIDTH |->
        AVS_READDATA >= 32'(WIDTH_MIN_TK) && AVS_READDATA <= 32'(WIDTH_MAX_TK))
        else $error("width out of range");
endmodule

// file: sim/ipg_ext_src.sv
`timescale 1ns/1ps
// ============================================================
// external gate and trigger source
module ipg_ext_src (
    // clock
    input  wire logic CLK,
    // level seen by the generator
    output      logic EXT
);
    // clean levels only, so every rise is one edge
    initial EXT = 1'b0;
    // level held until the next call
    task automatic set(input logic v);
        @(posedge CLK);
        EXT <= v;
    endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
// ============================================================
// register and pulse train tests
module testbench
    import ipg_pkg::*;
;
    logic          CLK = 1'b0;
    logic          RSTN = 1'b0;
    logic [AW-1:0] AVS_ADDRESS = '0;
    logic          AVS_READ = 1'b0;
    logic          AVS_WRITE = 1'b0;
    logic [DW-1:0] AVS_WRITEDATA = '0;
    logic [BW-1:0] AVS_BYTEENABLE = 4'hF;
    logic [DW-1:0] AVS_READDATA;
    logic          AVS_WAITREQUEST;
    logic          EXT_PULSE_IN;
    logic          PULSE_OUT;
    logic [DW-1:0] rdq;
    int            n_errors = 0;
    int            cmp_count = 0;
    int            cyc = 0;
    int            rises;
    int            first;
    // full words, except one lane-merged delay write
    ipg_top dut (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .EXT_PULSE_IN(EXT_PULSE_IN), .PULSE_OUT(PULSE_OUT));
    ipg_ext_src src (.CLK(CLK), .EXT(EXT_PULSE_IN));
    always #4 CLK = ~CLK;
    task automatic tally_and_finish();
        $display("mismatches %0d, compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one access, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        rdq = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    task automatic rc(input logic [AW-1:0] a, input logic [DW-1:0] e);
        bus(1'b0, a, DATA_ZERO);
        check($sformatf("reg %h", a), rdq, e);
    endtask
    // counts rising edges of the output, first one relative to the call
    task automatic watch(input int n);
        logic p;
        p = PULSE_OUT;
        rises = 0;
        first = -1;
        for (int i = 1; i <= n; i++) begin
            @(posedge CLK);
            #1;
            if (PULSE_OUT === 1'b1 && p === 1'b0) begin
                rises++;
                if (first < 0) first = i;
            end
            p = PULSE_OUT;
        end
    endtask
    // hang guard, well above the few thousand cycles needed
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // main sequence
    initial begin
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        rc(REG_PERIOD, 32'h0001_3880);
        rc(REG_RATE, 32'h0000_1388);
        rc(REG_WIDTH, 32'h0000_9C40);
        rc(REG_DELAY, DATA_ZERO);
        rc(REG_CTRL, DATA_ZERO);
        rc(5'h18, DATA_ZERO);
        // clamps at both ends, reciprocal recomputed
        bus(1'b1, REG_PERIOD, 32'h0000_0001);
        rc(REG_PERIOD, 32'h0000_000C);
        bus(1'b1, REG_RATE, 32'h0000_0001);
        rc(REG_RATE, 32'h0000_0019);
        rc(REG_PERIOD, 32'h00F4_2400);
        bus(1'b1, REG_RATE, 32'hFFFF_FFFF);
        rc(REG_RATE, 32'h01FC_1E20);
        rc(REG_PERIOD, 32'h0000_000C);
        bus(1'b1, REG_WIDTH, DATA_ZERO);
        rc(REG_WIDTH, 32'h0000_0001);
        bus(1'b1, REG_WIDTH, 32'h0000_0032);
        rc(REG_PERIOD, 32'h0000_0033);
        rc(REG_RATE, 32'h0077_AD41);
        // 40 ticks is exactly 125 clocks, external level ignored
        bus(1'b1, REG_PERIOD, 32'h0000_0028);
        bus(1'b1, REG_WIDTH, 32'h0000_000A);
        rc(REG_RATE, 32'h0098_9680);
        src.set(1'b1);
        repeat (300) @(posedge CLK);
        watch(2000);
        check("auto rises", 32'(rises), 32'h0000_0010);
        // gate mode masks the free-running train
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        src.set(1'b0);
        repeat (5) @(posedge CLK);
        watch(1000);
        check("gated off", {31'h0, PULSE_OUT} + 32'(rises), DATA_ZERO);
        src.set(1'b1);
        repeat (5) @(posedge CLK);
        watch(2000);
        check("gated on", 32'(rises), 32'h0000_0010);
        // trigger mode: one delayed pulse per rise, none from a held level
        src.set(1'b0);
        AVS_BYTEENABLE <= 4'h1;
        bus(1'b1, REG_DELAY, 32'hFFFF_FF08);
        AVS_BYTEENABLE <= 4'hF;
        bus(1'b1, REG_CTRL, 32'h0000_0002);
        repeat (300) @(posedge CLK);
        check("idle", {31'h0, PULSE_OUT}, DATA_ZERO);
        src.set(1'b1);
        watch(400);
        check("trig rises", 32'(rises), 32'h0000_0001);
        check("delay", 32'(first >= 25 && first <= 36), 32'h0000_0001);
        src.set(1'b0);
        // preset from the control register
        bus(1'b1, REG_CTRL, 32'h0000_0100);
        rc(REG_PERIOD, 32'h0001_3880);
        rc(REG_CTRL, DATA_ZERO);
        rc(REG_STATUS, 32'h0000_0002);
        tally_and_finish();
    end
endmodule
bind ipg_top ipg_assertions chk (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST));
